/* common/pms_pkg.sv */
// Shared constants, types and register map of the power-mode supervisor
package pms_pkg;
	// ----------------------------------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_SRAM  = 8'h04;
	localparam logic [7:0] OFS_IOCFG = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] SRAM_RST  = 32'h0000_0000;
	localparam logic [31:0] IOCFG_RST = 32'h0000_0000;
	// CTRL fields
	localparam int CTRL_LPSEL    = 0;
	localparam int CTRL_RANGE2   = 2;
	localparam int CTRL_SVDEN    = 3;
	localparam int CTRL_SVDFALL  = 4;
	localparam int CTRL_SVDRISE  = 5;
	localparam int CTRL_FLASHPD  = 6;
	localparam int CTRL_CLKREL   = 7;
	// SRAM fields: sleep clock gates and stop power switches
	localparam int SRAM_CLKOFF   = 0;
	localparam int SRAM_PWROFF   = 4;
	// STAT fields
	localparam int STAT_MODE     = 0;
	localparam int STAT_RANGE2   = 3;
	localparam int STAT_BELOW    = 4;
	localparam int STAT_FASTCLK  = 5;
	localparam int STAT_BORLVL   = 8;
	// Low-power mode selection codes
	localparam logic [1:0] LP_STOP0  = 2'h0;
	localparam logic [1:0] LP_STOP1  = 2'h1;
	localparam logic [1:0] LP_STBYRT = 2'h2;
	localparam logic [1:0] LP_STBY   = 2'h3;
	// Brownout level after power-on: lowest one (1.71 V)
	localparam logic [1:0] BOR_LVL_RST = 2'h0;
	// Frequency ceilings per core_supply range
	localparam logic [7:0] FREQ_R1_MHZ = 8'h64;
	localparam logic [7:0] FREQ_R2_MHZ = 8'h10;
	// ----------------------------------------------------------------
	// Unit and wake-source bit positions
	// ----------------------------------------------------------------
	localparam int U_RADIO = 11;
	localparam int NUNIT   = 13;
	localparam int W_ANY   = 15;
	localparam int NWAKE   = 16;
	// Units kept alive per mode (bit 12 = everything else)
	localparam logic [12:0] UM_RUN   = 13'h1fff;
	localparam logic [12:0] UM_STOP0 = 13'h0fff;
	localparam logic [12:0] UM_STOP1 = 13'h03ff;
	localparam logic [12:0] UM_STBRT = 13'h003d;
	localparam logic [12:0] UM_STBY  = 13'h001d;
	// Wake sources per mode (13 reset pin, 14 wake_pin, 15 any irq)
	localparam logic [15:0] WM_SLEEP = 16'h8000;
	localparam logic [15:0] WM_STOP0 = 16'h2fff;
	localparam logic [15:0] WM_STOP1 = 16'h23ff;
	localparam logic [15:0] WM_STBRT = 16'h603d;
	localparam logic [15:0] WM_STBY  = 16'h601d;

	typedef enum logic [2:0] {
		MODE_RUN, MODE_SLEEP, MODE_STOP0, MODE_STOP1, MODE_STBRT, MODE_STBY
	} pms_mode_t;

	typedef struct packed {
		logic       mainRegOn;
		logic       lowPowerRegulatorOn;
		logic       cpuClkOn;
		logic       flashOn;
		logic       flashClkOn;
		logic [1:0] sramClkOn;
		logic [1:0] sramPwrOn;
		logic       internalFastOscillatorOn;
		logic       slowOscOn;
		logic       ioRetain;
		logic       radioAvail;
		logic [7:0] freqLimMhz;
	} pms_pwr_t;
endpackage

/* core/pms_supervisor.sv */
// Power-mode supervisor: brownout hold, supply threshold detector, mode sequencer, AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none

module pms_supervisor #(
	parameter int NUM_WAKE_PINS = 8,
	parameter int NUM_IO        = 8
) (
	input  wire logic                        core_clk,
	input  wire logic                        resetn,
	input  wire logic                        clkEn,
	// AXI4-Lite slave
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Analog comparators and pins (asynchronous)
	input  wire logic [3:0]                  supplyBelowBor,
	input  wire logic                        supplyBelowSvd,
	input  wire logic [NUM_WAKE_PINS-1:0]    wakePin,
	input  wire logic [1:0]                  borLevelOption,
	// CPU and autonomous peripherals (core_clk domain)
	input  wire logic                        sleepReq,
	input  wire logic                        deepSleepReq,
	input  wire logic                        execFromSram,
	input  wire logic                        fastOscReq,
	input  wire logic                        busClkReq,
	input  wire logic [pms_pkg::NWAKE-1:0]   wakeSrc,
	// Outputs
	output logic                             brownoutResetHold_ff,
	output logic                             svdEvent_ff,
	output pms_pkg::pms_pwr_t                pwr_ff,
	output logic [pms_pkg::NUNIT-1:0]        unitActive_ff,
	output logic [pms_pkg::NWAKE-1:0]        wakeMask_ff,
	output logic                             sysClkFast_ff,
	output logic [2*NUM_IO-1:0]              ioPull_ff
);
	localparam int NSYNC = 5 + NUM_WAKE_PINS;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
	                                          input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic isMapped(input logic [7:0] a);
		return (a[7:2] == pms_pkg::OFS_CTRL[7:2]) || (a[7:2] == pms_pkg::OFS_SRAM[7:2]) ||
		       (a[7:2] == pms_pkg::OFS_IOCFG[7:2]) || (a[7:2] == pms_pkg::OFS_STAT[7:2]);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [NSYNC-1:0] syncA_ff;
	logic [NSYNC-1:0] syncB_ff;
	logic [NSYNC-1:0] syncC_ff;
	logic [NSYNC-1:0] pinFilt_ff;
	logic [3:0]       borBelow;
	logic             svdBelow;
	logic             svdBelowPrev_ff;

	// Three stages; a level is accepted only when stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			syncA_ff   <= '0;
			syncB_ff   <= '0;
			syncC_ff   <= '0;
			pinFilt_ff <= '0;
		end else if (clkEn) begin
			syncA_ff   <= {wakePin, supplyBelowSvd, supplyBelowBor};
			syncB_ff   <= syncA_ff;
			syncC_ff   <= syncB_ff;
			pinFilt_ff <= (syncB_ff & syncC_ff) | (pinFilt_ff & (syncB_ff ^ syncC_ff));
		end
	end

	assign borBelow = pinFilt_ff[3:0];
	assign svdBelow = pinFilt_ff[4];

	// ----------------------------------------------------------------
	// Brownout monitor
	// ----------------------------------------------------------------
	logic [1:0] borLvl_ff;
	logic       borCaptured_ff;

	// Option level is latched once after release; reset always starts at the lowest level
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			borLvl_ff      <= pms_pkg::BOR_LVL_RST;
			borCaptured_ff <= 1'b0;
		end else if (clkEn && !borCaptured_ff) begin
			borLvl_ff      <= borLevelOption;
			borCaptured_ff <= 1'b1;
		end
	end

	// Independent of mode: no state term gates the hold
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			brownoutResetHold_ff <= 1'b1;
		end else if (clkEn) begin
			brownoutResetHold_ff <= borBelow[borLvl_ff];
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0]         ctrl_ff;
	logic [31:0]         sram_ff;
	logic [31:0]         iocfg_ff;
	pms_pkg::pms_mode_t  state_ff;
	pms_pkg::pms_mode_t  nxt_state;
	logic                bamStop0_ff;
	logic                wrFire;
	logic [7:0]          awAddr_ff;
	logic                awHave_ff;
	logic [31:0]         wData_ff;
	logic [3:0]          wStrb_ff;
	logic                wHave_ff;
	logic [31:0]         statWord;

	assign wrFire = awHave_ff && wHave_ff && !s_axi_bvalid;

	// Write address and data are caught independently, in either order
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			awHave_ff     <= 1'b0;
			wHave_ff      <= 1'b0;
			awAddr_ff     <= 8'h00;
			wData_ff      <= 32'h0000_0000;
			wStrb_ff      <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else if (clkEn) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_ff     <= 1'b1;
				awAddr_ff     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_ff     <= 1'b1;
				wData_ff     <= s_axi_wdata;
				wStrb_ff     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wrFire) begin
				awHave_ff    <= 1'b0;
				wHave_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= isMapped(awAddr_ff) ? 2'h0 : 2'h2;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Software-visible configuration; detector disabled at reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctrl_ff  <= pms_pkg::CTRL_RST;
			sram_ff  <= pms_pkg::SRAM_RST;
			iocfg_ff <= pms_pkg::IOCFG_RST;
		end else if (clkEn && wrFire) begin
			if (awAddr_ff[7:2] == pms_pkg::OFS_CTRL[7:2]) begin
				ctrl_ff <= applyStrb(ctrl_ff, wData_ff, wStrb_ff) & 32'h0000_007f;
			end
			if (awAddr_ff[7:2] == pms_pkg::OFS_SRAM[7:2]) begin
				sram_ff <= applyStrb(sram_ff, wData_ff, wStrb_ff) & 32'h0000_0033;
			end
			if (awAddr_ff[7:2] == pms_pkg::OFS_IOCFG[7:2]) begin
				iocfg_ff <= applyStrb(iocfg_ff, wData_ff, wStrb_ff);
			end
		end
	end

	// Status word seen by software
	always_comb begin
		statWord = 32'h0000_0000;
		statWord[pms_pkg::STAT_MODE +: 3]   = state_ff;
		statWord[pms_pkg::STAT_RANGE2]      = ctrl_ff[pms_pkg::CTRL_RANGE2];
		statWord[pms_pkg::STAT_BELOW]       = svdBelow;
		statWord[pms_pkg::STAT_FASTCLK]     = sysClkFast_ff;
		statWord[pms_pkg::STAT_BORLVL +: 2] = borLvl_ff;
	end

	// Read channel answers one cycle after the address is taken
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else if (clkEn) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= isMapped(s_axi_araddr) ? 2'h0 : 2'h2;
				case (s_axi_araddr[7:2])
					pms_pkg::OFS_CTRL[7:2]:  s_axi_rdata <= ctrl_ff;
					pms_pkg::OFS_SRAM[7:2]:  s_axi_rdata <= sram_ff;
					pms_pkg::OFS_IOCFG[7:2]: s_axi_rdata <= iocfg_ff;
					pms_pkg::OFS_STAT[7:2]:  s_axi_rdata <= statWord;
					default:                 s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Supply threshold detector
	// ----------------------------------------------------------------
	// Edges are tracked while disabled too, so enabling never fakes an edge
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			svdBelowPrev_ff <= 1'b0;
			svdEvent_ff     <= 1'b0;
		end else if (clkEn) begin
			svdBelowPrev_ff <= svdBelow;
			svdEvent_ff     <= ctrl_ff[pms_pkg::CTRL_SVDEN] &&
			                   ((ctrl_ff[pms_pkg::CTRL_SVDFALL] && svdBelow && !svdBelowPrev_ff) ||
			                    (ctrl_ff[pms_pkg::CTRL_SVDRISE] && !svdBelow && svdBelowPrev_ff));
		end
	end

	// ----------------------------------------------------------------
	// Mode sequencer
	// ----------------------------------------------------------------
	logic [pms_pkg::NWAKE-1:0] curWake;
	logic [pms_pkg::NUNIT-1:0] curUnits;
	logic                      range2;
	logic                      wakeHit;
	logic                      lpExit;
	pms_pkg::pms_pwr_t         nxt_pwr;

	assign range2  = ctrl_ff[pms_pkg::CTRL_RANGE2];
	// The bit just below the any-event bit is the wake pin; filtered pins count there too
	assign wakeHit = (|(wakeSrc & curWake)) ||
	                 (curWake[pms_pkg::W_ANY-1] && (|pinFilt_ff[NSYNC-1:5]));
	assign lpExit  = (state_ff != pms_pkg::MODE_RUN) && (state_ff != pms_pkg::MODE_SLEEP) &&
	                 (nxt_state == pms_pkg::MODE_RUN);

	// Units and wake sources allowed in the present mode
	always_comb begin
		case (state_ff)
			pms_pkg::MODE_RUN: begin
				curUnits = pms_pkg::UM_RUN;
				curWake  = '0;
			end
			pms_pkg::MODE_SLEEP: begin
				curUnits = pms_pkg::UM_RUN;
				curWake  = pms_pkg::WM_SLEEP;
			end
			pms_pkg::MODE_STOP0: begin
				curUnits = pms_pkg::UM_STOP0;
				curWake  = pms_pkg::WM_STOP0;
			end
			pms_pkg::MODE_STOP1: begin
				curUnits = pms_pkg::UM_STOP1;
				curWake  = pms_pkg::WM_STOP1;
			end
			pms_pkg::MODE_STBRT: begin
				curUnits = pms_pkg::UM_STBRT;
				curWake  = pms_pkg::WM_STBRT;
			end
			pms_pkg::MODE_STBY: begin
				curUnits = pms_pkg::UM_STBY;
				curWake  = pms_pkg::WM_STBY;
			end
			default: begin
				curUnits = pms_pkg::UM_RUN;
				curWake  = '0;
			end
		endcase
		if (range2) begin
			curUnits[pms_pkg::U_RADIO] = 1'b0;
			curWake[pms_pkg::U_RADIO]  = 1'b0;
		end
	end

	// Next mode: entry from run only on software request; Stop 1 and Stop 0 then swap on busClkReq
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			pms_pkg::MODE_RUN: begin
				if (deepSleepReq) begin
					case (ctrl_ff[pms_pkg::CTRL_LPSEL +: 2])
						pms_pkg::LP_STOP0:  nxt_state = pms_pkg::MODE_STOP0;
						pms_pkg::LP_STOP1:  nxt_state = pms_pkg::MODE_STOP1;
						pms_pkg::LP_STBYRT: nxt_state = pms_pkg::MODE_STBRT;
						default:            nxt_state = pms_pkg::MODE_STBY;
					endcase
				end else if (sleepReq) begin
					nxt_state = pms_pkg::MODE_SLEEP;
				end
			end
			pms_pkg::MODE_STOP1: begin
				if (wakeHit) begin
					nxt_state = pms_pkg::MODE_RUN;
				end else if (busClkReq) begin
					nxt_state = pms_pkg::MODE_STOP0;
				end
			end
			pms_pkg::MODE_STOP0: begin
				if (wakeHit) begin
					nxt_state = pms_pkg::MODE_RUN;
				end else if (bamStop0_ff && !busClkReq) begin
					nxt_state = pms_pkg::MODE_STOP1;
				end
			end
			pms_pkg::MODE_SLEEP, pms_pkg::MODE_STBRT, pms_pkg::MODE_STBY: begin
				if (wakeHit) begin
					nxt_state = pms_pkg::MODE_RUN;
				end
			end
			default: nxt_state = pms_pkg::MODE_RUN;
		endcase
	end

	// Mode register; bamStop0 marks a Stop 0 borrowed from Stop 1
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_ff    <= pms_pkg::MODE_RUN;
			bamStop0_ff <= 1'b0;
		end else if (clkEn) begin
			state_ff    <= nxt_state;
			bamStop0_ff <= (nxt_state == pms_pkg::MODE_STOP0) &&
			               (bamStop0_ff || state_ff == pms_pkg::MODE_STOP1);
		end
	end

	// Exit sets the fast clock; a software release in the same cycle loses
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sysClkFast_ff <= 1'b1;
		end else if (clkEn) begin
			if (lpExit) begin
				sysClkFast_ff <= 1'b1;
			end else if (wrFire && awAddr_ff[7:2] == pms_pkg::OFS_CTRL[7:2] && wStrb_ff[0] &&
			             wData_ff[pms_pkg::CTRL_CLKREL]) begin
				sysClkFast_ff <= 1'b0;
			end
		end
	end

	// Power, clock and memory controls per mode
	always_comb begin
		nxt_pwr = '0;
		nxt_pwr.slowOscOn  = 1'b1;
		nxt_pwr.freqLimMhz = range2 ? pms_pkg::FREQ_R2_MHZ : pms_pkg::FREQ_R1_MHZ;
		case (state_ff)
			pms_pkg::MODE_RUN, pms_pkg::MODE_SLEEP: begin
				nxt_pwr.mainRegOn                = 1'b1;
				nxt_pwr.cpuClkOn                 = (state_ff == pms_pkg::MODE_RUN);
				nxt_pwr.flashOn                  = !(ctrl_ff[pms_pkg::CTRL_FLASHPD] && execFromSram);
				nxt_pwr.flashClkOn               = nxt_pwr.flashOn;
				nxt_pwr.sramPwrOn                = 2'h3;
				nxt_pwr.sramClkOn                = (state_ff == pms_pkg::MODE_SLEEP) ?
				                                   ~sram_ff[pms_pkg::SRAM_CLKOFF +: 2] : 2'h3;
				nxt_pwr.internalFastOscillatorOn = 1'b1;
				nxt_pwr.radioAvail               = !range2;
			end
			pms_pkg::MODE_STOP0: begin
				nxt_pwr.mainRegOn                = 1'b1;
				nxt_pwr.sramPwrOn                = ~sram_ff[pms_pkg::SRAM_PWROFF +: 2];
				nxt_pwr.internalFastOscillatorOn = fastOscReq || busClkReq;
				nxt_pwr.radioAvail               = !range2;
			end
			pms_pkg::MODE_STOP1, pms_pkg::MODE_STBRT: begin
				nxt_pwr.lowPowerRegulatorOn = 1'b1;
				nxt_pwr.sramPwrOn           = ~sram_ff[pms_pkg::SRAM_PWROFF +: 2];
				nxt_pwr.ioRetain            = (state_ff == pms_pkg::MODE_STBRT);
			end
			pms_pkg::MODE_STBY: begin
				nxt_pwr.ioRetain = 1'b1;
			end
			default: nxt_pwr.mainRegOn = 1'b1;
		endcase
	end

	// Registered outputs
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pwr_ff        <= '0;
			unitActive_ff <= '0;
			wakeMask_ff   <= '0;
			ioPull_ff     <= '0;
		end else if (clkEn) begin
			pwr_ff        <= nxt_pwr;
			unitActive_ff <= curUnits;
			wakeMask_ff   <= curWake;
			ioPull_ff     <= iocfg_ff[2*NUM_IO-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_bor_hold: assert property (@(posedge core_clk) disable iff (!resetn || !clkEn)
		borBelow[borLvl_ff] |=> brownoutResetHold_ff) else $error("brownout hold missing");
	chk_bor_default: assert property (@(posedge core_clk)
		!resetn |=> borLvl_ff == pms_pkg::BOR_LVL_RST) else $error("brownout level not lowest");
	chk_svd_fall: assert property (@(posedge core_clk) disable iff (!resetn || !clkEn)
		ctrl_ff[pms_pkg::CTRL_SVDEN] && ctrl_ff[pms_pkg::CTRL_SVDFALL] && $rose(svdBelow)
		|=> svdEvent_ff) else $error("detector fall event lost");
	chk_run_reset: assert property (@(posedge core_clk)
		!resetn |=> state_ff == pms_pkg::MODE_RUN) else $error("not in run after reset");
	chk_sleep_wake: assert property (@(posedge core_clk) disable iff (!resetn || !clkEn)
		state_ff == pms_pkg::MODE_SLEEP && wakeSrc[pms_pkg::W_ANY]
		|=> state_ff == pms_pkg::MODE_RUN) else $error("sleep ignored wake");
	chk_stop0_power: assert property (@(posedge core_clk) disable iff (!resetn || !clkEn)
		state_ff == pms_pkg::MODE_STOP0 |=> pwr_ff.mainRegOn && !pwr_ff.flashOn && !pwr_ff.cpuClkOn)
		else $error("stop0 power wrong");
	chk_standby_regs: assert property (@(posedge core_clk) disable iff (!resetn || !clkEn)
		state_ff == pms_pkg::MODE_STBY |=> !pwr_ff.mainRegOn && !pwr_ff.lowPowerRegulatorOn)
		else $error("standby regulator on");
	chk_range2_limit: assert property (@(posedge core_clk) disable iff (!resetn || !clkEn)
		range2 |=> pwr_ff.freqLimMhz == pms_pkg::FREQ_R2_MHZ && !pwr_ff.radioAvail)
		else $error("range2 limit wrong");
	chk_exit_fastclk: assert property (@(posedge core_clk) disable iff (!resetn || !clkEn)
		lpExit |=> sysClkFast_ff && state_ff == pms_pkg::MODE_RUN) else $error("exit clock not fast");
	chk_stop1_bam: assert property (@(posedge core_clk) disable iff (!resetn || !clkEn)
		state_ff == pms_pkg::MODE_STOP1 && busClkReq && !wakeHit |=> state_ff == pms_pkg::MODE_STOP0)
		else $error("bus clock request ignored");
endmodule

`default_nettype wire

/* verification/pms_cpu_model.sv */
// Behavioural model of the CPU and autonomous peripherals facing the supervisor
`timescale 1ns/100ps
`default_nettype none
module pms_cpu_model (
	input  wire logic        core_clk,
	input  wire logic        cpuClkOn,
	input  wire logic        goDeep,
	input  wire logic [15:0] evt,
	output logic             deepSleepReq,
	output logic [15:0]      wakeSrc
);
	// A sleeping CPU cannot withdraw its request, so it only drops once the CPU clock (cpuClkOn) stops
	always_ff @(posedge core_clk) begin
		deepSleepReq <= goDeep ? 1'b1 : (cpuClkOn ? deepSleepReq : 1'b0);
		wakeSrc      <= evt; // Peripheral events arrive one cycle after they are commanded
	end
endmodule
`default_nettype wire

/* verification/pms_supervisor_bench.sv */
// Self-checking bench for the power-mode supervisor
`timescale 1ns/100ps
`default_nettype none
module pms_supervisor_bench;
	logic              core_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, goDeep = 1'b0, seen = 1'b0;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic              s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic              s_axi_rvalid, svdEvent_ff, sysClkFast_ff, brownoutResetHold_ff, deepSleepReq;
	logic              sleepReq = 1'b0, execFromSram = 1'b0, fastOscReq = 1'b0, busClkReq = 1'b0;
	logic              supplyBelowSvd = 1'b0;
	logic [1:0]        s_axi_bresp, s_axi_rresp, rsp, borLevelOption = 2'h0;
	logic [3:0]        s_axi_wstrb = 4'hf, supplyBelowBor = 4'h0;
	logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, wakePin = 8'h00;
	logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, rdData;
	logic [15:0]       wakeSrc, wakeMask_ff, ioPull_ff, evt = 16'h0000;
	logic [12:0]       unitActive_ff;
	pms_pkg::pms_pwr_t pwr_ff;
	logic [12:0]       unitMask [5] = '{pms_pkg::UM_STOP0, pms_pkg::UM_STOP1, pms_pkg::UM_STBRT, pms_pkg::UM_STBY,
	                   pms_pkg::UM_STOP0 & ~(13'h1 << pms_pkg::U_RADIO)};
	logic [15:0]       wakeMaskExp [5] = '{pms_pkg::WM_STOP0, pms_pkg::WM_STOP1, pms_pkg::WM_STBRT, pms_pkg::WM_STBY,
	                   pms_pkg::WM_STOP0 & ~(16'h1 << pms_pkg::U_RADIO)};
	int                n_mismatch = 0, checks = 0;

	always #50 core_clk = ~core_clk;

	pms_supervisor pms_supervisor_i (.core_clk, .resetn, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.supplyBelowBor, .supplyBelowSvd, .wakePin, .borLevelOption, .sleepReq, .deepSleepReq, .execFromSram,
		.fastOscReq, .busClkReq, .wakeSrc, .brownoutResetHold_ff, .svdEvent_ff, .pwr_ff, .unitActive_ff,
		.wakeMask_ff, .sysClkFast_ff, .ioPull_ff);
	pms_cpu_model pms_cpu_model_i (.core_clk, .cpuClkOn(pwr_ff.cpuClkOn), .goDeep, .evt, .deepSleepReq, .wakeSrc);

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One AXI4-Lite transfer; ready is read at the negedge, where it already holds its value for the next edge
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tr, done;
		@(posedge core_clk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		done = 1'b0;
		while (!done) begin
			@(negedge core_clk);
			{ta, tw} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready};
			tr = s_axi_arvalid & s_axi_arready;
			done = wr ? s_axi_bvalid : s_axi_rvalid;
			{rsp, rdData} = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tr) s_axi_arvalid <= 1'b0;
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
	endtask

	task automatic print_verdict;
		if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		print_verdict;
	end

	// Brownout hold, status after reset, bus error, detector, then every low-power mode in turn
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge core_clk);
		cmp("bor_hold", 0, brownoutResetHold_ff);
		supplyBelowBor <= 4'h1;
		repeat (6) @(posedge core_clk);
		cmp("bor_hold", 1, brownoutResetHold_ff);
		supplyBelowBor <= 4'h0;
		repeat (6) @(posedge core_clk);
		axi(1'b0, pms_pkg::OFS_STAT, 32'h0);
		cmp("stat", 32'h0, rdData & 32'h307);
		axi(1'b0, 8'h10, 32'h0);
		cmp("slverr", 2'b10, rsp);
		axi(1'b1, pms_pkg::OFS_IOCFG, 32'h0000_a5c3);
		axi(1'b0, pms_pkg::OFS_IOCFG, 32'h0);
		cmp("iocfg", 32'h0000_a5c3, rdData);
		cmp("io_pull", 16'ha5c3, ioPull_ff);
		cmp("freq_r1", pms_pkg::FREQ_R1_MHZ, pwr_ff.freqLimMhz);
		axi(1'b1, pms_pkg::OFS_CTRL, 32'h18);
		supplyBelowSvd <= 1'b1;
		repeat (12) begin
			@(negedge core_clk);
			seen = seen | svdEvent_ff;
		end
		cmp("svd_event", 1, seen);
		// Sleep request held while frozen must wait for the enable; flash stays off while running from SRAM
		axi(1'b1, pms_pkg::OFS_SRAM, 32'h0000_0021);
		axi(1'b1, pms_pkg::OFS_CTRL, 32'h0000_0040);
		{clkEn, sleepReq, execFromSram} <= 3'b011;
		repeat (3) @(posedge core_clk);
		cmp("frozen", 1, pwr_ff.cpuClkOn);
		clkEn <= 1'b1;
		@(posedge core_clk);
		sleepReq <= 1'b0;
		repeat (3) @(posedge core_clk);
		cmp("sleep_cpu", 0, pwr_ff.cpuClkOn);
		cmp("sleep_sram", 2'b10, pwr_ff.sramClkOn);
		cmp("flash_pd", 0, {pwr_ff.flashOn, pwr_ff.flashClkOn});
		{evt, execFromSram} <= {16'h8000, 1'b0};
		repeat (4) @(posedge core_clk);
		evt <= 16'h0000;
		cmp("wake_cpu", 3'b111, {pwr_ff.cpuClkOn, pwr_ff.flashOn, pwr_ff.flashClkOn});
		// Pass 4 selects Stop 0 in range 2
		for (int i = 0; i < 5; i++) begin
			axi(1'b1, pms_pkg::OFS_CTRL, 32'h80 | i);
			repeat (2) @(posedge core_clk);
			cmp("fast_rel", 0, sysClkFast_ff);
			cmp("freq", i == 4 ? pms_pkg::FREQ_R2_MHZ : pms_pkg::FREQ_R1_MHZ, pwr_ff.freqLimMhz);
			cmp("radio", i != 4, pwr_ff.radioAvail);
			goDeep <= 1'b1;
			@(posedge core_clk);
			goDeep <= 1'b0;
			repeat (4) @(posedge core_clk);
			cmp("units", unitMask[i], unitActive_ff);
			cmp("lp_reg", (i == 1 || i == 2), pwr_ff.lowPowerRegulatorOn);
			cmp("wake", wakeMaskExp[i], wakeMask_ff);
			cmp("sram_pwr", i == 3 ? 2'b00 : 2'b01, pwr_ff.sramPwrOn);
			cmp("io_ret", i == 2 || i == 3, pwr_ff.ioRetain);
			if (i < 2) begin
				{busClkReq, fastOscReq} <= i ? 2'b10 : 2'b01;
				repeat (3) @(posedge core_clk);
				cmp("fast_osc", 1, pwr_ff.internalFastOscillatorOn);
				{busClkReq, fastOscReq} <= 2'b00;
				repeat (3) @(posedge core_clk);
			end
			// Standby leaves by a wake pin, which needs the pin filter's extra cycles
			if (i == 3) wakePin <= 8'h01;
			else evt <= 16'h2000;
			repeat (8) @(posedge core_clk);
			{evt, wakePin} <= 24'h00_0000;
			cmp("fast_sel", 1, sysClkFast_ff);
		end
		print_verdict;
	end
endmodule
`default_nettype wire
